// ===== shared/smx_cfg.svh
// Constants of the station management read mux: addresses, frame layout, status words.
// Assumes inclusion by bare name from files that also compile smx_pkg.
`ifndef SMX_CFG_SVH
`define SMX_CFG_SVH

// Fixed address of the embedded PHY
`define SMX_EMB_PHY_ADDR 5'h10

// Frame layout: preamble ones, opcodes, last bit index of each field
`define SMX_PRE_BITS 6'h20
`define SMX_OP_RD 2'h2
`define SMX_OP_WR 2'h1
`define SMX_OP_LAST 4'h1
`define SMX_ADDR_LAST 4'h4
`define SMX_TA_LAST 4'h1
`define SMX_DATA_LAST 4'hf

// Responder register map and reset values
`define SMX_REG_STATUS 5'h01
`define SMX_REG_SPEC 5'h1f
`define SMX_STAT_BASE 16'h7809
`define SMX_STAT_LINK_BIT 2
`define SMX_SPEC_SPD_BIT 1
`define SMX_SPEC_DUP_BIT 0
`define SMX_MEM_RST 16'h0000
`define SMX_MEM_WORDS 32

// Cycles after reset release before the strap is captured
`define SMX_STRAP_WAIT 2'h2

`endif

// ===== shared/smx_pkg.sv
// Types shared by the station management read mux.
// Assumes nothing beyond a SystemVerilog compiler.
package smx_pkg;

  typedef enum logic [2:0] {
    SMX_IDLE,
    SMX_START,
    SMX_OP,
    SMX_PHYAD,
    SMX_REGAD,
    SMX_TA,
    SMX_DATA
  } smx_state_t;

endpackage

// ===== shared/smx_mem_if.sv
// Carrier between the frame logic and the responder register memory.
// Assumes both ends run on sys_clk.
interface smx_mem_if;
  logic [4:0] rd_addr;
  logic [15:0] rd_data;
  logic wr_en;
  logic [4:0] wr_addr;
  logic [15:0] wr_data;

  modport master (
    output rd_addr,
    output wr_en,
    output wr_addr,
    output wr_data,
    input rd_data
  );

  modport slave (
    input rd_addr,
    input wr_en,
    input wr_addr,
    input wr_data,
    output rd_data
  );
endinterface

// ===== rtl/smx_status_mem.sv
// Register memory that the device answers from while acting as a PHY.
// Assumes writes and reads come from smx_top on the same clock.
`include "smx_cfg.svh"

module smx_status_mem (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Access port
  smx_mem_if.slave mem
);

  logic [15:0] word_q [`SMX_MEM_WORDS];

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < `SMX_MEM_WORDS; i++) begin
        word_q[i] <= `SMX_MEM_RST;
      end
    end else if (mem.wr_en) begin
      word_q[mem.wr_addr] <= mem.wr_data;
    end
  end

  // Registered read keeps the answer path off the memory array
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem.rd_data <= `SMX_MEM_RST;
    end else begin
      mem.rd_data <= word_q[mem.rd_addr];
    end
  end

endmodule

// ===== rtl/smx_top.sv
// Station management path: read-data mux in MAC mode, PHY responder in PHY mode.
// Assumes mac_* and emb_* come from logic on sys_clk; ext_* and the strap are pins.
`include "smx_cfg.svh"

module smx_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Configuration
  input wire logic phy_mode_strap,
  input wire logic [4:0] external_phy_address,
  // Basic status reported in PHY mode
  input wire logic link_up,
  input wire logic speed_100,
  input wire logic full_duplex,
  // MAC core station side
  input wire logic mac_mdc,
  input wire logic mac_mdio_o,
  input wire logic mac_mdio_oe,
  output logic mdin,
  // Embedded PHY
  input wire logic emb_mdio_i,
  input wire logic emb_mdio_oe,
  output logic emb_mdc,
  output logic emb_mdio,
  // External management pins
  input wire logic ext_mdc_i,
  output logic ext_mdc_o,
  output logic ext_mdc_oe,
  input wire logic ext_mdio_i,
  output logic ext_mdio_o,
  output logic ext_mdio_oe,
  // Mode and last addressed PHY
  output logic phy_mode,
  output logic [4:0] managed_phy_address
);

  smx_mem_if mem_bus ();

  smx_status_mem u_mem (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .mem(mem_bus.slave)
  );

  function automatic logic is_emb(input logic [4:0] addr);
    return addr == `SMX_EMB_PHY_ADDR;
  endfunction

  function automatic logic is_ext_resp(input logic [4:0] addr, input logic [4:0] cfg);
    return addr == {cfg[4:1], 1'b0};
  endfunction

  // Pin synchronisers: strap, data, clock
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {phy_mode_strap, ext_mdio_i, ext_mdc_i};
      sync2_q <= sync1_q;
    end
  end

  // Strap is taken once, after the synchroniser has filled past reset;
  // the counter parks one step beyond the capture so it never repeats
  logic [1:0] strap_cnt_q;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_cnt_q <= 2'h0;
    end else if (strap_cnt_q != `SMX_STRAP_WAIT + 2'h1) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
    end
  end

  // Second stage holds the pin level only from the second edge on
  logic strap_take;
  assign strap_take = strap_cnt_q == `SMX_STRAP_WAIT;
  logic phy_mode_d;
  logic phy_mode_held_q;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phy_mode_held_q <= 1'b0;
    end else if (strap_take) begin
      phy_mode_held_q <= sync2_q[2];
    end
  end

  assign phy_mode_d = phy_mode_held_q;

  // Frame decoder watches the MAC core in MAC mode and the pins in PHY mode
  logic mdc_s;
  logic mdio_s;
  logic mdc_prev_q;
  logic rise;

  always_comb begin
    mdc_s = phy_mode_d ? sync2_q[0] : mac_mdc;
    mdio_s = phy_mode_d ? sync2_q[1] : mac_mdio_o;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mdc_prev_q <= 1'b0;
    end else begin
      mdc_prev_q <= mdc_s;
    end
  end

  assign rise = mdc_s & ~mdc_prev_q;

  smx_pkg::smx_state_t state_q;
  logic [5:0] pre_cnt_q;
  logic [3:0] bit_cnt_q;
  logic [15:0] shift_q;
  logic [1:0] op_q;
  logic [4:0] addr_q;
  logic [4:0] reg_q;
  logic sel_emb_q;
  logic match_q;
  logic [4:0] addr_next;
  logic [15:0] shift_next;
  logic last_bit;

  always_comb begin
    shift_next = {shift_q[14:0], mdio_s};
    addr_next = shift_next[4:0];
    unique case (state_q)
      smx_pkg::SMX_OP: last_bit = bit_cnt_q == `SMX_OP_LAST;
      smx_pkg::SMX_PHYAD: last_bit = bit_cnt_q == `SMX_ADDR_LAST;
      smx_pkg::SMX_REGAD: last_bit = bit_cnt_q == `SMX_ADDR_LAST;
      smx_pkg::SMX_TA: last_bit = bit_cnt_q == `SMX_TA_LAST;
      smx_pkg::SMX_DATA: last_bit = bit_cnt_q == `SMX_DATA_LAST;
      default: last_bit = 1'b0;
    endcase
  end

  // Frame sequencer, one step per rising management clock edge
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= smx_pkg::SMX_IDLE;
      pre_cnt_q <= 6'h0;
      bit_cnt_q <= 4'h0;
      shift_q <= 16'h0;
      op_q <= 2'h0;
      addr_q <= 5'h0;
      reg_q <= 5'h0;
      sel_emb_q <= 1'b0;
      match_q <= 1'b0;
    end else if (rise) begin
      shift_q <= shift_next;
      bit_cnt_q <= last_bit ? 4'h0 : bit_cnt_q + 4'h1;
      unique case (state_q)
        smx_pkg::SMX_IDLE: begin
          if (mdio_s) begin
            if (pre_cnt_q != `SMX_PRE_BITS) begin
              pre_cnt_q <= pre_cnt_q + 6'h1;
            end
          end else if (pre_cnt_q == `SMX_PRE_BITS) begin
            state_q <= smx_pkg::SMX_START;
          end else begin
            pre_cnt_q <= 6'h0;
          end
          bit_cnt_q <= 4'h0;
        end
        smx_pkg::SMX_START: begin
          pre_cnt_q <= 6'h0;
          bit_cnt_q <= 4'h0;
          state_q <= mdio_s ? smx_pkg::SMX_OP : smx_pkg::SMX_IDLE;
        end
        smx_pkg::SMX_OP: begin
          if (last_bit) begin
            op_q <= shift_next[1:0];
            // Unknown opcodes drop the frame rather than guess a direction
            if (shift_next[1:0] == `SMX_OP_RD || shift_next[1:0] == `SMX_OP_WR) begin
              state_q <= smx_pkg::SMX_PHYAD;
            end else begin
              state_q <= smx_pkg::SMX_IDLE;
            end
          end
        end
        smx_pkg::SMX_PHYAD: begin
          if (last_bit) begin
            addr_q <= addr_next;
            sel_emb_q <= is_emb(addr_next);
            match_q <= phy_mode_d && is_ext_resp(addr_next, external_phy_address);
            state_q <= smx_pkg::SMX_REGAD;
          end
        end
        smx_pkg::SMX_REGAD: begin
          if (last_bit) begin
            reg_q <= addr_next;
            state_q <= smx_pkg::SMX_TA;
          end
        end
        smx_pkg::SMX_TA: begin
          if (last_bit) begin
            state_q <= smx_pkg::SMX_DATA;
          end
        end
        smx_pkg::SMX_DATA: begin
          if (last_bit) begin
            state_q <= smx_pkg::SMX_IDLE;
          end
        end
      endcase
    end
  end

  logic in_read;
  assign in_read = (state_q == smx_pkg::SMX_TA || state_q == smx_pkg::SMX_DATA)
    && op_q == `SMX_OP_RD;

  // Responder memory access; writes land at the last data bit
  logic wr_en_q;
  logic [15:0] wr_data_q;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_en_q <= 1'b0;
      wr_data_q <= 16'h0;
    end else begin
      wr_en_q <= rise && state_q == smx_pkg::SMX_DATA && last_bit && match_q
        && op_q == `SMX_OP_WR;
      wr_data_q <= shift_next;
    end
  end

  assign mem_bus.wr_en = wr_en_q;
  assign mem_bus.wr_addr = reg_q;
  assign mem_bus.wr_data = wr_data_q;
  assign mem_bus.rd_addr = reg_q;

  // Status word is a constant with a live link bit; speed and duplex bits of the speed word are live; everything else reads back the memory
  logic [15:0] answer;

  always_comb begin
    answer = mem_bus.rd_data;
    if (reg_q == `SMX_REG_STATUS) begin
      answer = `SMX_STAT_BASE;
      answer[`SMX_STAT_LINK_BIT] = link_up;
    end else if (reg_q == `SMX_REG_SPEC) begin
      answer[`SMX_SPEC_SPD_BIT] = speed_100;
      answer[`SMX_SPEC_DUP_BIT] = full_duplex;
    end
  end

  // PHY-mode answer: zero in the second turnaround bit, then data MSB first
  logic resp_oe_q;
  logic resp_out_q;
  logic [15:0] resp_sh_q;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      resp_oe_q <= 1'b0;
      resp_out_q <= 1'b0;
      resp_sh_q <= 16'h0;
    end else if (rise) begin
      if (state_q == smx_pkg::SMX_TA && !last_bit && match_q && in_read) begin
        resp_oe_q <= 1'b1;
        resp_out_q <= 1'b0;
        resp_sh_q <= answer;
      end else if (resp_oe_q && state_q == smx_pkg::SMX_DATA && last_bit) begin
        resp_oe_q <= 1'b0;
        resp_out_q <= 1'b0;
      end else if (resp_oe_q) begin
        resp_out_q <= resp_sh_q[15];
        resp_sh_q <= {resp_sh_q[14:0], 1'b0};
      end
    end
  end

  // Pin, embedded PHY and MAC-side outputs, all registered
  logic mdin_q;
  logic emb_mdc_q;
  logic emb_mdio_q;
  logic ext_mdc_o_q;
  logic ext_mdc_oe_q;
  logic ext_mdio_o_q;
  logic ext_mdio_oe_q;
  logic emb_read;

  assign emb_read = in_read && sel_emb_q;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mdin_q <= 1'b1;
      emb_mdc_q <= 1'b0;
      emb_mdio_q <= 1'b1;
      ext_mdc_o_q <= 1'b0;
      ext_mdc_oe_q <= 1'b0;
      ext_mdio_o_q <= 1'b0;
      ext_mdio_oe_q <= 1'b0;
    end else begin
      emb_mdc_q <= mdc_s;
      emb_mdio_q <= mdio_s;
      mdin_q <= emb_read ? emb_mdio_i : sync2_q[1];
      if (phy_mode_d) begin
        // Clock is an input in PHY mode; the embedded PHY shares the pin
        ext_mdc_o_q <= 1'b0;
        ext_mdc_oe_q <= 1'b0;
        ext_mdio_o_q <= emb_read ? emb_mdio_i : resp_out_q;
        ext_mdio_oe_q <= emb_read ? emb_mdio_oe : resp_oe_q;
      end else begin
        ext_mdc_o_q <= mac_mdc;
        ext_mdc_oe_q <= 1'b1;
        ext_mdio_o_q <= mac_mdio_o;
        ext_mdio_oe_q <= mac_mdio_oe;
      end
    end
  end

  assign mdin = mdin_q;
  assign emb_mdc = emb_mdc_q;
  assign emb_mdio = emb_mdio_q;
  assign ext_mdc_o = ext_mdc_o_q;
  assign ext_mdc_oe = ext_mdc_oe_q;
  assign ext_mdio_o = ext_mdio_o_q;
  assign ext_mdio_oe = ext_mdio_oe_q;
  assign phy_mode = phy_mode_held_q;
  assign managed_phy_address = addr_q;

endmodule

// ===== verification/smx_asserts.sv
// Checker on the ports of smx_top, bound after the module.
// Assumes mac_mdc is held low while reset is applied.
module smx_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Station side
  input wire logic mac_mdc,
  input wire logic mac_mdio_o,
  input wire logic mac_mdio_oe,
  input wire logic mdin,
  // Embedded PHY side
  input wire logic emb_mdc,
  input wire logic emb_mdio,
  // Pins and mode
  input wire logic ext_mdc_i,
  input wire logic ext_mdc_o,
  input wire logic ext_mdc_oe,
  input wire logic ext_mdio_o,
  input wire logic ext_mdio_oe,
  input wire logic phy_mode,
  input wire logic [4:0] managed_phy_address
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  logic [4:0] rise_q;

  // Pin clock rises seen while the answer holds the data pin
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rise_q <= 5'h00;
    end else if (!ext_mdio_oe) begin
      rise_q <= 5'h00;
    end else if ($rose(ext_mdc_i)) begin
      rise_q <= rise_q + 5'h01;
    end
  end

  chk_reset_values: assert property ($fell(sys_rst) |-> mdin && !ext_mdio_oe && !phy_mode)
    else $error("Outputs wrong after reset");
  chk_mdc_forward: assert property (!$past(sys_rst) && !phy_mode && !$past(phy_mode) |->
    ext_mdc_o == $past(mac_mdc))
    else $error("Pin clock does not follow station clock");
  chk_mdio_forward: assert property (!$past(sys_rst) && !phy_mode && !$past(phy_mode) |->
    {ext_mdio_o, ext_mdio_oe} == $past({mac_mdio_o, mac_mdio_oe}))
    else $error("Pin data does not follow station data");
  chk_emb_forward: assert property (!$past(sys_rst) && !phy_mode && !$past(phy_mode) |->
    {emb_mdc, emb_mdio} == $past({mac_mdc, mac_mdio_o}))
    else $error("Embedded PHY does not see station clock and data");
  chk_mdc_drive_mode: assert property (!$past(sys_rst) && $stable(phy_mode) |->
    ext_mdc_oe == !phy_mode)
    else $error("Clock pin drive wrong for mode");
  chk_mode_held: assert property ($past(phy_mode) |-> phy_mode)
    else $error("Mode changed after capture");
  chk_ta_low: assert property (phy_mode && $rose(ext_mdio_oe) &&
    managed_phy_address != 5'h10 |-> !ext_mdio_o)
    else $error("Turnaround bit not low");
  chk_answer_span: assert property (phy_mode && $fell(ext_mdio_oe) |-> rise_q == 5'h11)
    else $error("Answer not 17 clock periods long");
  chk_even_address: assert property (phy_mode && ext_mdio_oe &&
    managed_phy_address != 5'h10 |-> !managed_phy_address[0])
    else $error("Answer to an odd address");
endmodule

bind smx_top smx_asserts smx_asserts_i (
  .sys_clk, .sys_rst, .mac_mdc, .mac_mdio_o, .mac_mdio_oe, .mdin, .emb_mdc, .emb_mdio,
  .ext_mdc_i, .ext_mdc_o,
  .ext_mdc_oe, .ext_mdio_o, .ext_mdio_oe, .phy_mode, .managed_phy_address
);

// ===== verification/smx_far_phy.sv
// External PHY model answering reads on the management pins.
// Assumes mdio is the resolved pin level, pulled up when released.
module smx_far_phy #(
  parameter logic [4:0] ADDR = 5'h03
) (
  // Pins
  input wire logic mdc,
  input wire logic mdio,
  // Answer
  input wire logic [15:0] word,
  output logic drv_oe,
  output logic drv_d
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] sr;
  logic [4:0] cnt;

  initial begin
    sr = 14'h0000;
    cnt = 5'h00;
    drv_oe = 1'b0;
    drv_d = 1'b1;
  end

  // Drives just after each rise, so a bit stands a whole period
  always @(posedge mdc) begin
    sr <= {sr[12:0], mdio};
    if (cnt == 5'h00 && sr[12:4] == {4'h6, ADDR}) begin
      cnt <= 5'h12;
    end else if (cnt != 5'h00) begin
      cnt <= cnt - 5'h01;
      drv_oe <= cnt > 5'h01;
      drv_d <= cnt == 5'h12 ? 1'b0 : word[cnt - 5'h02];
    end
  end
endmodule

// ===== verification/tb_top.sv
// Bench for smx_top: reads in MAC mode, reads and writes in PHY mode.
// Assumes smx_far_phy stands behind the pins at address 03h.
`include "smx_cfg.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, sys_rst, phy_mode_strap, link_up, speed_100, full_duplex, mdin, emb_mdc;
  logic mdc, sta_o, sta_oe, emb_mdio_i, emb_mdio_oe, far_oe, far_d, emb_mdio, phy_mode;
  logic ext_mdc_o, ext_mdc_oe, ext_mdio_o, ext_mdio_oe;
  logic [4:0] external_phy_address, managed_phy_address, pa;
  logic [15:0] far_word, got, w;
  logic [15:0] exp_q[$];
  int num_errors, n_checks, cyc;
  event done;
  wire mac_mdc = !phy_mode_strap && mdc;
  wire mac_mdio_oe = !phy_mode_strap && sta_oe;
  wire ext_mdc_i = phy_mode_strap ? mdc : ext_mdc_oe && ext_mdc_o;
  // Data pin has a pull-up
  wire ext_mdio_i = ext_mdio_oe ? ext_mdio_o : far_oe ? far_d :
    (phy_mode_strap && sta_oe) ? sta_o : 1'b1;

  smx_top smx_top_i (
    .sys_clk, .sys_rst, .phy_mode_strap, .external_phy_address, .link_up, .speed_100,
    .full_duplex, .mac_mdc, .mac_mdio_o(sta_o), .mac_mdio_oe, .mdin, .emb_mdio_i,
    .emb_mdio_oe, .emb_mdc, .emb_mdio, .ext_mdc_i, .ext_mdc_o, .ext_mdc_oe, .ext_mdio_i,
    .ext_mdio_o, .ext_mdio_oe, .phy_mode, .managed_phy_address
  );
  smx_far_phy smx_far_phy_i (
    .mdc(ext_mdc_i), .mdio(ext_mdio_i), .word(far_word), .drv_oe(far_oe), .drv_d(far_d)
  );

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = !sys_clk;
  end

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Nine frames of 512 cycles; the ceiling leaves ample margin
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end

  always @(done) begin
    check("read data", exp_q.pop_front(), got);
  end

  task automatic do_reset(input logic strap);
    phy_mode_strap = strap;
    sys_rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 check("mode", {15'h0000, strap}, {15'h0000, phy_mode});
  endtask

  // One link bit: 4 cycles low, sample, 4 cycles high (320 ns)
  task automatic bit_io(input logic d, output logic s);
    sta_o = d;
    mdc = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 s = phy_mode_strap ? ext_mdio_i : mdin;
    mdc = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
    input logic [15:0] ex);
    logic [63:0] f;
    logic [15:0] ew;
    logic s;
    f = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
    ew = 16'($urandom);
    if (pa == `SMX_EMB_PHY_ADDR && !phy_mode_strap) ex = ew;
    for (int i = 63; i >= 0; i--) begin
      sta_oe = !(op == `SMX_OP_RD && i < 18);
      emb_mdio_i = i < 16 ? ew[i] : 1'b1;
      emb_mdio_oe = i < 16;
      bit_io(f[i], s);
      got = {got[14:0], s};
    end
    sta_oe = 1'b1;
    check("address", {11'h000, pa}, {11'h000, managed_phy_address});
    if (op == `SMX_OP_RD) begin
      exp_q.push_back(ex);
      ->done;
    end
  endtask

  initial begin
    sys_rst = 1'b1;
    mdc = 1'b0;
    sta_o = 1'b1;
    sta_oe = 1'b1;
    emb_mdio_i = 1'b1;
    emb_mdio_oe = 1'b0;
    phy_mode_strap = 1'b0;
    void'($urandom(32'h9f79));
    far_word = 16'($urandom);
    external_phy_address = 5'($urandom) | 5'h09;
    {link_up, speed_100, full_duplex} = 3'($urandom);
    do_reset(1'b0);
    for (int k = 0; k < 3; k++) begin
      pa = k == 0 ? `SMX_EMB_PHY_ADDR : k == 1 ? 5'h03 : 5'h11;
      frame(`SMX_OP_RD, 5'h01, 16'h0000, k == 1 ? far_word : 16'hffff);
    end
    $display("Test mac_read_mux done");
    do_reset(1'b1);
    pa = {external_phy_address[4:1], 1'b0};
    w = `SMX_STAT_BASE;
    w[`SMX_STAT_LINK_BIT] = link_up;
    frame(`SMX_OP_RD, `SMX_REG_STATUS, 16'h0000, w);
    w = 16'($urandom);
    frame(`SMX_OP_WR, 5'h05, w, 16'h0000);
    frame(`SMX_OP_RD, 5'h05, 16'h0000, w);
    frame(`SMX_OP_WR, `SMX_REG_SPEC, w, 16'h0000);
    w[`SMX_SPEC_SPD_BIT] = speed_100;
    w[`SMX_SPEC_DUP_BIT] = full_duplex;
    frame(`SMX_OP_RD, `SMX_REG_SPEC, 16'h0000, w);
    pa[0] = 1'b1;
    frame(`SMX_OP_RD, `SMX_REG_STATUS, 16'h0000, 16'hffff);
    $display("Test phy_responder done");
    // Let the watching process take the last note before the verdict
    repeat (2) @(posedge sys_clk);
    close_out();
  end
endmodule
